// ===== hw/watchdog_pkg.sv
// package: register map, field layout and timing constants of the windowed watchdog
`default_nettype none
package watchdog_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h01;
  localparam logic [7:0] UNLOCK_OFFSET = 8'h02;
  localparam logic [7:0] UNLOCK_KEY = 8'hd8;
  localparam int STATUS_LOCK_BIT = 7;
  localparam int STATUS_BUSY_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int OSC_HZ = 32768;
  localparam int TICK_HZ = 1024;
  localparam int OSC_DIV = OSC_HZ / TICK_HZ;
  localparam logic [4:0] OSC_DIV_LAST = 5'(OSC_DIV - 1);
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
  localparam logic [1:0] SYNC_TICKS = 2'h2;
  localparam logic [4:0] RESET_HOLD_CYCLES = 5'h10;
  localparam logic [3:0] PERIOD_MAX_CODE = 4'hb;
  localparam logic [13:0] PERIOD_BASE_TICKS = 14'h0008;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] window;
    logic [3:0] period;
  } wd_cfg_type;
  typedef enum logic [1:0] {
    ST_OFF,
    ST_NORMAL,
    ST_CLOSED,
    ST_OPEN
  } wd_state_type;
endpackage
`default_nettype wire

// ===== hw/windowed_watchdog_timer.sv
// windowed watchdog timer: register port, tick divider, sync, window/normal counting, reset pulse
// Functional notes
// - enabled counter resets system on missed refresh
// - refresh instruction restarts time-out counting
// - count on 1.024 kHz from oscillator
// - config and refresh cross domains safely
// - eleven periods from 8 ms to 8 s
// - normal mode and window mode
// - window mode resets on early or late refresh
// - keeps counting in active and sleep
// - resets even when main clock fails; here all logic, reset pulse included, runs on ref_clk_in
// - unlock key and lock guard the settings
// - non-zero period selector enables the watchdog
// - open period follows closed period
// - lock blocks config, cleared only in debug
//
// Added by the designer: the placing of the registers and the plain strobed port.
`default_nettype none
module windowed_watchdog_timer
  import watchdog_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic low_power_oscillator_in,
  input wire logic watchdog_refresh_instruction_in,
  input wire logic debug_mode_in,
  input wire logic debug_halt_in,
  input wire logic [7:0] fuse_cfg_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [7:0] rd_data_out,
  output logic sys_reset_req_out,
  output logic sync_pending_flag_out
);
  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // reserved codes above the last one fall back to the longest period
  // code n counts 8 << (n - 1) ticks
  function automatic logic [13:0] ticks_of(input logic [3:0] code);
    logic [3:0] c;
    c = (code > PERIOD_MAX_CODE) ? PERIOD_MAX_CODE : code;
    ticks_of = PERIOD_BASE_TICKS << (c - 4'h1);
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic osc_meta_reg;
  logic osc_sync_reg;
  logic osc_prev_reg;
  logic [4:0] div_reg;
  logic [4:0] div_next;
  logic tick_reg;
  logic boot_reg;
  wd_cfg_type shadow_reg;
  wd_cfg_type shadow_next;
  wd_cfg_type active_reg;
  logic lock_reg;
  logic lock_next;
  logic [2:0] unlock_reg;
  logic [2:0] unlock_next;
  logic cfg_pend_reg;
  logic [1:0] cfg_wait_reg;
  logic ref_pend_reg;
  logic [1:0] ref_wait_reg;
  wd_state_type state_reg;
  wd_state_type state_next;
  logic [13:0] cnt_reg;
  logic [13:0] cnt_next;
  logic [4:0] hold_reg;
  logic fire;
  logic [7:0] rd_data_reg;
  logic rst_out_reg;
  logic busy_out_reg;

  // ----------------------------------------------------------------
  // tick from the low-power oscillator
  // ----------------------------------------------------------------
  // the divider turns 32 oscillator edges into one tick enable
  // only rising edges count; the level itself carries no timing
  wire osc_edge = osc_sync_reg & ~osc_prev_reg;
  wire div_wrap = osc_edge && (div_reg == OSC_DIV_LAST);
  assign div_next = div_wrap ? 5'h00 : (osc_edge ? div_reg + 5'h01 : div_reg);

  // the meta stage is read only by the second stage
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      osc_meta_reg <= 1'b0;
      osc_sync_reg <= 1'b0;
      osc_prev_reg <= 1'b0;
      div_reg <= 5'h00;
      tick_reg <= 1'b0;
    end else begin
      osc_meta_reg <= low_power_oscillator_in;
      osc_sync_reg <= osc_meta_reg;
      osc_prev_reg <= osc_sync_reg;
      div_reg <= div_next;
      tick_reg <= div_wrap;
    end
  end

  // ----------------------------------------------------------------
  // register port, unlock and lock
  // ----------------------------------------------------------------
  // any protected write, taken or refused, closes the unlock window
  wire wr_ctrl = wr_en_in && (addr_in == CTRL_OFFSET);
  wire wr_status = wr_en_in && (addr_in == STATUS_OFFSET);
  wire wr_key = wr_en_in && (addr_in == UNLOCK_OFFSET) && (wr_data_in == UNLOCK_KEY);
  wire unlocked = (unlock_reg != 3'h0);
  wire ctrl_ok = wr_ctrl && unlocked && !lock_reg && !cfg_pend_reg;
  wire lock_set = wr_status && unlocked && wr_data_in[STATUS_LOCK_BIT];
  wire lock_clr = wr_status && unlocked && !wr_data_in[STATUS_LOCK_BIT] && debug_mode_in;
  wire fuse_lock = boot_reg && (fuse_cfg_in[3:0] != 4'h0);

  assign unlock_next = wr_key ? UNLOCK_CYCLES :
                       ((wr_ctrl || wr_status) ? 3'h0 : (unlocked ? unlock_reg - 3'h1 : 3'h0));
  assign shadow_next = boot_reg ? wd_cfg_type'(fuse_cfg_in) : (ctrl_ok ? wd_cfg_type'(wr_data_in) : shadow_reg);
  // a set beats a debug clear that lands in the same cycle
  assign lock_next = (fuse_lock || lock_set) ? 1'b1 : (lock_clr ? 1'b0 : lock_reg);

  // the pending bit stays up until the tick domain has taken the write
  wire [7:0] status_word = {lock_reg, 6'h00, cfg_pend_reg};
  wire [7:0] rd_mux = (addr_in == CTRL_OFFSET) ? shadow_reg :
                      ((addr_in == STATUS_OFFSET) ? status_word : 8'h00);

  // boot_reg loads the fuse strap in the first cycle after reset release
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      boot_reg <= 1'b1;
      shadow_reg <= CTRL_RESET;
      lock_reg <= 1'b0;
      unlock_reg <= 3'h0;
      rd_data_reg <= 8'h00;
    end else begin
      boot_reg <= 1'b0;
      shadow_reg <= shadow_next;
      lock_reg <= lock_next;
      unlock_reg <= unlock_next;
      rd_data_reg <= rd_en_in ? rd_mux : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // crossing into the tick domain: config and refresh
  // ----------------------------------------------------------------
  // both wait SYNC_TICKS ticks, so they land on the second tick, one to two tick periods after the request
  // writes are refused while pending, so only a settled shadow is copied across
  wire cfg_start = boot_reg || ctrl_ok;
  wire cfg_apply = cfg_pend_reg && tick_reg && (cfg_wait_reg == SYNC_TICKS - 2'h1);
  wire ref_apply = ref_pend_reg && tick_reg && (ref_wait_reg == SYNC_TICKS - 2'h1);

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg_pend_reg <= 1'b0;
      cfg_wait_reg <= 2'h0;
      active_reg <= CTRL_RESET;
    end else if (cfg_start) begin
      cfg_pend_reg <= 1'b1;
      cfg_wait_reg <= 2'h0;
    end else if (cfg_apply) begin
      cfg_pend_reg <= 1'b0;
      active_reg <= shadow_reg;
    end else if (cfg_pend_reg && tick_reg) begin
      cfg_wait_reg <= cfg_wait_reg + 2'h1;
    end
  end

  // a refresh issued while one is pending merges with it
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ref_pend_reg <= 1'b0;
      ref_wait_reg <= 2'h0;
    end else if (ref_apply) begin
      ref_pend_reg <= watchdog_refresh_instruction_in;
      ref_wait_reg <= 2'h0;
    end else if (watchdog_refresh_instruction_in && !ref_pend_reg) begin
      ref_pend_reg <= 1'b1;
      ref_wait_reg <= 2'h0;
    end else if (ref_pend_reg && tick_reg) begin
      ref_wait_reg <= ref_wait_reg + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // counting and windows
  // ----------------------------------------------------------------
  // period code zero parks the counter in the off state
  wire enabled = (active_reg.period != 4'h0);
  wire win_mode = (active_reg.window != 4'h0);
  wire [13:0] open_ticks = ticks_of(active_reg.period);
  wire [13:0] closed_ticks = ticks_of(active_reg.window);
  // 14 bits hold the longest period of 8192 ticks
  wire [13:0] cnt_inc = cnt_reg + 14'h0001;

  // ref_apply and tick_reg coincide, so every count and refresh step happens on a tick
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    fire = 1'b0;
    case (state_reg)
      ST_OFF: begin
        cnt_next = 14'h0000;
        if (enabled) begin
          state_next = ST_NORMAL;
        end
      end
      ST_NORMAL: begin
        if (ref_apply) begin
          cnt_next = 14'h0000;
          // with a window set, the first refresh arms the closed slot
          state_next = win_mode ? ST_CLOSED : ST_NORMAL;
        end else if (tick_reg) begin
          cnt_next = cnt_inc;
          if (cnt_inc >= open_ticks) begin
            fire = 1'b1;
            cnt_next = 14'h0000;
          end
        end
      end
      ST_CLOSED: begin
        if (ref_apply) begin
          fire = 1'b1;
          cnt_next = 14'h0000;
          state_next = ST_NORMAL;
        end else if (tick_reg) begin
          cnt_next = cnt_inc;
          if (cnt_inc >= closed_ticks) begin
            cnt_next = 14'h0000;
            state_next = ST_OPEN;
          end
        end
      end
      ST_OPEN: begin
        if (ref_apply) begin
          cnt_next = 14'h0000;
          state_next = ST_CLOSED;
        end else if (tick_reg) begin
          cnt_next = cnt_inc;
          if (cnt_inc >= open_ticks) begin
            fire = 1'b1;
            cnt_next = 14'h0000;
            state_next = ST_NORMAL;
          end
        end
      end
      default: begin
        state_next = ST_OFF;
        cnt_next = 14'h0000;
      end
    endcase
    if (!enabled) begin
      state_next = ST_OFF;
      cnt_next = 14'h0000;
    end else if (!win_mode && state_reg != ST_OFF) begin
      state_next = ST_NORMAL;
    end
  end

  // a debug halt clears the count and re-runs one normal period first
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= ST_OFF;
      cnt_reg <= 14'h0000;
    end else if (debug_halt_in) begin
      state_reg <= enabled ? ST_NORMAL : ST_OFF;
      cnt_reg <= 14'h0000;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // reset request pulse
  // ----------------------------------------------------------------
  // held for several clocks so the reset controller cannot miss it
  // a halt drops a due fire rather than delaying it
  // the busy flag takes the next pending value, so it equals the status bit
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hold_reg <= 5'h00;
      rst_out_reg <= 1'b0;
      busy_out_reg <= 1'b0;
    end else begin
      if (fire && !debug_halt_in) begin
        hold_reg <= RESET_HOLD_CYCLES;
      end else if (hold_reg != 5'h00) begin
        hold_reg <= hold_reg - 5'h01;
      end
      rst_out_reg <= (fire && !debug_halt_in) || (hold_reg > 5'h01);
      busy_out_reg <= cfg_start || (cfg_pend_reg && !cfg_apply);
    end
  end

  assign rd_data_out = rd_data_reg;
  assign sys_reset_req_out = rst_out_reg;
  assign sync_pending_flag_out = busy_out_reg;
endmodule
`default_nettype wire

// ===== verification/core_model.sv
// partner: core issuing refresh pulses, and the free-running low-power oscillator
`default_nettype none
module core_model (
  input wire logic clk_in,
  input wire logic issue_in,
  output logic osc_out,
  output logic refresh_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic half_reg = 1'b0;
  logic osc_reg = 1'b0;
  assign osc_out = osc_reg;
  // sped up: a level change every two clocks keeps a tick at 128 clocks
  always @(posedge clk_in) begin
    half_reg <= ~half_reg;
    if (half_reg) begin
      osc_reg <= ~osc_reg;
    end
  end
  // refresh only ever arrives as the one-cycle instruction pulse
  always @(posedge clk_in) begin
    refresh_out <= issue_in;
  end
endmodule
`default_nettype wire

// ===== verification/wdt_assertions.sv
// checker: properties on the watchdog's register port and reset request
`default_nettype none
module wdt_assertions
  import watchdog_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic low_power_oscillator_in,
  input wire logic debug_halt_in,
  input wire logic [7:0] addr_in,
  input wire logic rd_en_in,
  input wire logic [7:0] rd_data_out,
  input wire logic sys_reset_req_out,
  input wire logic sync_pending_flag_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------
  // oscillator edges counted while sync is pending
  // --------
  logic osc_prev_reg;
  logic [7:0] osc_cnt_reg;
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      osc_prev_reg <= 1'b0;
      osc_cnt_reg <= 8'h00;
    end else begin
      osc_prev_reg <= low_power_oscillator_in;
      if (!sync_pending_flag_out) begin
        osc_cnt_reg <= 8'h00;
      end else if (low_power_oscillator_in && !osc_prev_reg) begin
        osc_cnt_reg <= osc_cnt_reg + 8'h01;
      end
    end
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  // --------
  // properties
  // --------
  // three ticks of 32 edges, plus slack for the input synchroniser
  sync_bound_a: assert property (osc_cnt_reg <= 8'h64)
    else $error("config sync pending too long");
  pulse_hold_a: assert property ($rose(sys_reset_req_out) |-> sys_reset_req_out[*8] ##1 sys_reset_req_out[*8] ##1 !sys_reset_req_out)
    else $error("reset pulse length wrong");
  pulse_gap_a: assert property ($fell(sys_reset_req_out) |-> !sys_reset_req_out[*3])
    else $error("reset pulse retriggered");
  halt_quiet_a: assert property (debug_halt_in && !sys_reset_req_out |=> !sys_reset_req_out)
    else $error("reset raised while halted");
  status_mirror_a: assert property (rd_en_in && addr_in == STATUS_OFFSET |=> rd_data_out[0] == $past(sync_pending_flag_out))
    else $error("pending bit and flag differ");
  status_spare_a: assert property (rd_en_in && addr_in == STATUS_OFFSET |=> rd_data_out[6:1] == 6'h00)
    else $error("status spare bits set");
  unmapped_zero_a: assert property (rd_en_in && addr_in > UNLOCK_OFFSET |=> rd_data_out == 8'h00)
    else $error("unmapped read not zero");
  read_idle_a: assert property (!rd_en_in |=> rd_data_out == 8'h00)
    else $error("read data not idle");
endmodule
`default_nettype wire

// ===== verification/windowed_watchdog_timer_test.sv
// testbench: register tasks and timed refresh scenarios for the watchdog
`default_nettype none
module windowed_watchdog_timer_test import watchdog_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_prev = 1'b0;
  logic [7:0] rcount = 8'h00;
  logic nrst, issue, osc, refresh, dbg_mode, dbg_halt, wr_en, rd_en, sys_rst, sync_flag;
  logic [7:0] addr, wdata, rd_data, fuse;
  int errors, num_checks;
  always #20 clk = ~clk;
  core_model PARTNER (.clk_in(clk), .issue_in(issue), .osc_out(osc), .refresh_out(refresh));
  windowed_watchdog_timer DUT (.ref_clk_in(clk), .nrst_in(nrst), .low_power_oscillator_in(osc),
    .watchdog_refresh_instruction_in(refresh), .debug_mode_in(dbg_mode), .debug_halt_in(dbg_halt),
    .fuse_cfg_in(fuse), .addr_in(addr), .wr_data_in(wdata), .wr_en_in(wr_en), .rd_en_in(rd_en),
    .rd_data_out(rd_data), .sys_reset_req_out(sys_rst), .sync_pending_flag_out(sync_flag));
  // --------
  // tasks
  // --------
  always @(posedge clk) begin
    rst_prev <= sys_rst;
    if (sys_rst === 1'b1 && rst_prev === 1'b0) begin
      rcount <= rcount + 8'h01;
    end
  end
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task unlock_wr(input logic [7:0] a, input logic [7:0] d);
    wr(UNLOCK_OFFSET, UNLOCK_KEY);
    wr(a, d);
  endtask
  task rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    check("read data", rd_data, exp);
  endtask
  task kick;
    @(posedge clk);
    issue <= 1'b1;
    @(posedge clk);
    issue <= 1'b0;
  endtask
  // a few cycles first, so the flag has had time to rise
  task wait_sync;
    int n;
    n = 0;
    repeat (4) @(posedge clk);
    while (sync_flag !== 1'b0 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    check("sync pending", {7'h00, sync_flag}, 8'h00);
  endtask
  task rwait(input int n, input logic [7:0] exp);
    repeat (n) @(posedge clk);
    check("reset pulses", rcount, exp);
  endtask
  task conclude;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // --------
  // scenarios
  // --------
  initial begin
    nrst = 1'b0;
    {issue, dbg_mode, dbg_halt, wr_en, rd_en} = 5'h00;
    {addr, wdata, fuse} = 24'h000000;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    wait_sync;
    rchk(CTRL_OFFSET, CTRL_RESET);
    rchk(STATUS_OFFSET, 8'h00);
    rchk(8'h05, 8'h00);
    wr(CTRL_OFFSET, 8'h01);
    rchk(CTRL_OFFSET, 8'h00);
    rwait(2000, 8'h00);
    unlock_wr(CTRL_OFFSET, 8'h01);
    rchk(CTRL_OFFSET, 8'h01);
    wait_sync;
    repeat (6) begin
      kick;
      rwait(600, 8'h00);
    end
    kick;
    rwait(800, 8'h00);
    rwait(1000, 8'h01);
    dbg_halt <= 1'b1;
    rwait(2500, 8'h01);
    dbg_halt <= 1'b0;
    kick;
    unlock_wr(STATUS_OFFSET, 8'h80);
    rchk(STATUS_OFFSET, 8'h80);
    unlock_wr(CTRL_OFFSET, 8'h11);
    rchk(CTRL_OFFSET, 8'h01);
    unlock_wr(STATUS_OFFSET, 8'h00);
    rchk(STATUS_OFFSET, 8'h80);
    @(posedge clk);
    dbg_mode <= 1'b1;
    unlock_wr(STATUS_OFFSET, 8'h00);
    rchk(STATUS_OFFSET, 8'h00);
    dbg_mode <= 1'b0;
    unlock_wr(CTRL_OFFSET, 8'h11);
    rchk(CTRL_OFFSET, 8'h11);
    wait_sync;
    // first refresh only arms; later ones land in the open slot
    repeat (3) begin
      kick;
      rwait(1300, 8'h01);
    end
    kick;
    rwait(300, 8'h01);
    kick;
    rwait(800, 8'h02);
    // arm again and never refresh: the open slot runs out
    kick;
    rwait(2400, 8'h03);
    // second reset with a strapped period: enabled and locked from boot
    nrst <= 1'b0;
    fuse <= 8'h01;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rchk(CTRL_OFFSET, 8'h01);
    rchk(STATUS_OFFSET, 8'h81);
    wait_sync;
    unlock_wr(CTRL_OFFSET, 8'h00);
    rchk(CTRL_OFFSET, 8'h01);
    rwait(1300, 8'h04);
    conclude;
  end
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    conclude;
  end
endmodule
bind windowed_watchdog_timer wdt_assertions CHK (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
  .low_power_oscillator_in(low_power_oscillator_in), .debug_halt_in(debug_halt_in), .addr_in(addr_in),
  .rd_en_in(rd_en_in), .rd_data_out(rd_data_out), .sys_reset_req_out(sys_reset_req_out),
  .sync_pending_flag_out(sync_pending_flag_out));
`default_nettype wire
